// *** hw/fhp_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - input ack only on selected I/O reads
// - input ack undriven in memory mode
// - raise DMA request when data is ready
// - DMA direction set by read/write strobes
// - hold request until ack, then drop, rearm
// - DMA request undriven when not selected
// - I/O read strobe drives read data
// - card enables and A0 pick byte
// - odd byte reachable on low lanes
// - two IDE selects: task file, control block
// - DMA ack means 16-bit, no selects
// - writes latch on write strobe rising edge
// - memory mode output enable reads all spaces
// - I/O mode output enable reads attributes only
// - attribute space on output enable reads when space select low
// - three low address lines pick task register
module fhp_port (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [fhp_pkg::ADDR_W-1:0] addr,
    input wire logic [fhp_pkg::DATA_W-1:0] data_in,
    output logic [fhp_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic low_byte_card_enable_n,
    input wire logic high_byte_card_enable_n,
    input wire logic attr_space_n,
    input wire logic output_enable_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic dma_ack_n,
    input wire logic master_slave_select_n,
    input wire logic ide_mode_select_n,
    output logic input_ack_n,
    output logic input_ack_oe,
    output logic dma_request,
    output logic dma_request_oe,
    output logic insert_detect_a_n,
    output logic insert_detect_b_n,
    output logic master_slave_pullup_en,
    input wire logic io_mode_enable,
    input wire logic dev_selected,
    input wire logic dma_enable,
    input wire logic dma_pending,
    input wire logic [fhp_pkg::DATA_W-1:0] core_rd_data,
    output logic ide_mode,
    output logic is_master,
    output logic rd_active,
    output fhp_pkg::fhp_space_t rd_space,
    output logic [fhp_pkg::ADDR_W-1:0] rd_addr,
    output logic wr_pulse,
    output fhp_pkg::fhp_space_t wr_space,
    output logic [fhp_pkg::ADDR_W-1:0] wr_addr,
    output logic [fhp_pkg::DATA_W-1:0] wr_data,
    output logic [1:0] wr_byte_en
);
    import fhp_pkg::*;

    logic rst_ff1;
    logic rst_n;
    logic [SYNC_W-1:0] pin_s;
    logic ce1_s, ce2_s, reg_s, oe_s, io_read_strobe_n_s, io_write_strobe_n_s, dma_ack_n_s, master_slave_select_n_s, ide_mode_select_n_s;
    logic [ADDR_W-1:0] a_s;
    logic [DATA_W-1:0] d_s;
    logic ide;
    logic word;
    logic [2:0] lane;
    logic [2:0] rd_lane;
    fhp_space_t acc_io;
    fhp_space_t acc_mem;
    fhp_space_t rd_now;
    logic io_write_strobe_n_prev;
    fhp_space_t hold_space;
    logic [ADDR_W-1:0] hold_addr;
    logic [DATA_W-1:0] hold_data;
    logic [1:0] hold_be;
    fhp_dma_state_t dma_state;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_ff1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_n <= rst_ff1;
        end
    end

    // bus lines share the strobe delay; they must be stable while a strobe is low
    fhp_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({data_in, addr, ide_mode_select_n, master_slave_select_n, dma_ack_n,
            io_write_strobe_n, io_read_strobe_n, output_enable_n, attr_space_n,
            high_byte_card_enable_n, low_byte_card_enable_n}),
        .sync_out(pin_s)
    );

    assign ce1_s = pin_s[IX_CE1];
    assign ce2_s = pin_s[IX_CE2];
    assign reg_s = pin_s[IX_REG];
    assign oe_s = pin_s[IX_OE];
    assign io_read_strobe_n_s = pin_s[IX_IO_READ_STROBE_N];
    assign io_write_strobe_n_s = pin_s[IX_IO_WRITE_STROBE_N];
    assign dma_ack_n_s = pin_s[IX_DMA_ACK_N];
    assign master_slave_select_n_s = pin_s[IX_MASTER_SLAVE_SELECT_N];
    assign ide_mode_select_n_s = pin_s[IX_IDE_MODE_SELECT_N];
    assign a_s = pin_s[IX_DATA-1:IX_ADDR];
    assign d_s = pin_s[SYNC_W-1:IX_DATA];

    ////////////////////////////////////////////////////////////////////////
    assign ide = !ide_mode_select_n_s;
    assign ide_mode = ide;
    assign is_master = ide && !master_slave_select_n_s;
    assign master_slave_pullup_en = ide;
    assign insert_detect_a_n = 1'b0;
    assign insert_detect_b_n = 1'b0;

    // in IDE the card enable pins carry the two chip selects
    function automatic fhp_space_t pick_space(input logic io_cycle);
        if (ide) begin
            if (!dev_selected) begin
                pick_space = sp_none;
            end else if (!dma_ack_n_s && dma_enable) begin
                pick_space = sp_dma;
            end else if (!ce1_s) begin
                pick_space = sp_task;
            end else if (!ce2_s) begin
                pick_space = sp_ctrl;
            end else begin
                pick_space = sp_none;
            end
        end else if (ce1_s && ce2_s) begin
            pick_space = sp_none;
        end else if (io_cycle) begin
            pick_space = (io_mode_enable && !reg_s) ? sp_io : sp_none;
        end else if (!reg_s) begin
            pick_space = sp_attr;
        end else begin
            pick_space = io_mode_enable ? sp_none : sp_common;
        end
    endfunction

    function automatic logic [2:0] lane_sel(input logic ce1_n, input logic ce2_n, input logic a0,
        input logic ide_on, input logic ide_word);
        if (ide_on) begin
            lane_sel = ide_word ? LANE_WORD : LANE_EVEN;
        end else begin
            case ({ce2_n, ce1_n})
                2'b00: lane_sel = LANE_WORD;
                2'b10: lane_sel = a0 ? LANE_ODD_LOW : LANE_EVEN;
                2'b01: lane_sel = LANE_ODD;
                default: lane_sel = LANE_NONE;
            endcase
        end
    endfunction

    always_comb begin
        acc_io = pick_space(1'b1);
        acc_mem = pick_space(1'b0);
        word = (acc_io == sp_dma) || (acc_io == sp_task && a_s[TF_ADDR_W-1:0] == TF_DATA_INDEX);
        lane = lane_sel(ce1_s, ce2_s, a_s[0], ide, word);
        if (!io_read_strobe_n_s && (ide || io_mode_enable)) begin
            rd_now = acc_io;
        end else if (!oe_s && !ide) begin
            rd_now = acc_mem;
        end else begin
            rd_now = sp_none;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: two cycles from synced strobe to driven data, core answers in between
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_active <= 1'b0;
            rd_space <= sp_none;
            rd_addr <= ADDR_RST;
            rd_lane <= LANE_NONE;
        end else begin
            rd_active <= rd_now != sp_none;
            rd_space <= rd_now;
            rd_addr <= ide ? {{(ADDR_W-TF_ADDR_W){1'b0}}, a_s[TF_ADDR_W-1:0]} : a_s;
            rd_lane <= lane;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= DATA_RST;
            data_oe <= 1'b0;
        end else begin
            data_oe <= rd_active;
            data_out[7:0] <= rd_lane[LN_SWAP] ? core_rd_data[15:8] :
                (rd_lane[LN_EVEN] ? core_rd_data[7:0] : 8'h00);
            data_out[15:8] <= (rd_lane[LN_ODD] && !rd_lane[LN_SWAP]) ? core_rd_data[15:8] : 8'h00;
        end
    end

    assign input_ack_n = !(rd_active && rd_space == sp_io);
    assign input_ack_oe = !ide && io_mode_enable;

    ////////////////////////////////////////////////////////////////////////
    // selects may lift together with the strobe, so the last low-strobe sample is kept
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_write_strobe_n_prev <= 1'b1;
            hold_space <= sp_none;
            hold_addr <= ADDR_RST;
            hold_data <= DATA_RST;
            hold_be <= 2'b00;
        end else begin
            io_write_strobe_n_prev <= io_write_strobe_n_s;
            if (!io_write_strobe_n_s) begin
                hold_space <= acc_io;
                hold_addr <= ide ? {{(ADDR_W-TF_ADDR_W){1'b0}}, a_s[TF_ADDR_W-1:0]} : a_s;
                hold_data <= lane[LN_SWAP] ? {d_s[7:0], d_s[7:0]} : d_s;
                hold_be <= {lane[LN_ODD], lane[LN_EVEN]};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pulse <= 1'b0;
            wr_space <= sp_none;
            wr_addr <= ADDR_RST;
            wr_data <= DATA_RST;
            wr_byte_en <= 2'b00;
        end else begin
            wr_pulse <= io_write_strobe_n_s && !io_write_strobe_n_prev && hold_space != sp_none && (ide || io_mode_enable);
            if (io_write_strobe_n_s && !io_write_strobe_n_prev) begin
                wr_space <= hold_space;
                wr_addr <= hold_addr;
                wr_data <= hold_data;
                wr_byte_en <= hold_be;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_state <= dma_idle;
        end else begin
            case (dma_state)
                dma_idle: if (ide && dma_enable && dma_pending) dma_state <= dma_req;
                dma_req: begin
                    if (!(ide && dma_enable)) begin
                        dma_state <= dma_idle;
                    end else if (!dma_ack_n_s) begin
                        dma_state <= dma_ack_wait;
                    end
                end
                dma_ack_wait: if (dma_ack_n_s) dma_state <= dma_idle;
                default: dma_state <= dma_idle;
            endcase
        end
    end

    assign dma_request = dma_state == dma_req;
    assign dma_request_oe = ide && dev_selected;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_dma_start;
        dma_state == dma_idle && ide && dma_enable && dma_pending;
    endsequence
    sequence s_req_ack;
        dma_state == dma_req && ide && dma_enable && !dma_ack_n_s;
    endsequence
    sequence s_rearm;
        dma_state == dma_ack_wait && dma_ack_n_s ##1 ide && dma_enable && dma_pending;
    endsequence
    sequence s_wr_rise;
        io_write_strobe_n_s && !io_write_strobe_n_prev && hold_space != sp_none && (ide || io_mode_enable);
    endsequence

    input_ack_n_sel_a: assert property (!input_ack_n |-> !$past(io_read_strobe_n_s) && io_mode_enable && !ide)
        else $error("input ack without selected io read");
    input_ack_n_mem_a: assert property (!ide && !io_mode_enable |-> !input_ack_oe)
        else $error("input ack driven in memory mode");
    dma_request_raise_a: assert property (s_dma_start |=> dma_request)
        else $error("dma request not raised");
    dma_request_drop_a: assert property (s_req_ack |=> !dma_request)
        else $error("dma request held after ack");
    dma_request_rearm_a: assert property (s_rearm |=> dma_request)
        else $error("dma request not rearmed");
    dma_request_hiz_a: assert property (!dev_selected |-> !dma_request_oe)
        else $error("dma request driven while unselected");
    rd_drive_a: assert property ((!io_read_strobe_n_s && ide && dev_selected && !ce1_s) [*3] |-> data_oe)
        else $error("read data not driven");
    wr_edge_a: assert property (s_wr_rise |=> wr_pulse)
        else $error("write not taken on rising edge");
    wr_only_a: assert property (wr_pulse |-> $past(io_write_strobe_n_s) && !$past(io_write_strobe_n_s, 2))
        else $error("write without strobe edge");
    lane_odd_a: assert property (!ide && !ce1_s && ce2_s && a_s[0] && rd_now != sp_none
        |=> ##1 data_out[7:0] == $past(core_rd_data[15:8]))
        else $error("odd byte missing on low lane");
    tf_addr_a: assert property (wr_pulse && wr_space == sp_task |-> wr_addr[ADDR_W-1:TF_ADDR_W] == '0)
        else $error("task file address too wide");
    detect_a: assert property (!insert_detect_a_n && !insert_detect_b_n)
        else $error("insert detect not low");
endmodule

// *** hw/fhp_pkg.sv ***
package fhp_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int TF_ADDR_W = 3;
    localparam logic [TF_ADDR_W-1:0] TF_DATA_INDEX = 3'h0;
    // bit positions of the pin vector through the synchroniser
    localparam int IX_CE1 = 0;
    localparam int IX_CE2 = 1;
    localparam int IX_REG = 2;
    localparam int IX_OE = 3;
    localparam int IX_IO_READ_STROBE_N = 4;
    localparam int IX_IO_WRITE_STROBE_N = 5;
    localparam int IX_DMA_ACK_N = 6;
    localparam int IX_MASTER_SLAVE_SELECT_N = 7;
    localparam int IX_IDE_MODE_SELECT_N = 8;
    localparam int IX_ADDR = 9;
    localparam int IX_DATA = IX_ADDR + ADDR_W;
    localparam int SYNC_W = IX_DATA + DATA_W;
    // strobes and selects idle high, bus lines low
    localparam logic [SYNC_W-1:0] SYNC_RST = 36'h0000001ff;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    // lane select fields
    localparam int LN_EVEN = 0;
    localparam int LN_ODD = 1;
    localparam int LN_SWAP = 2;
    localparam logic [2:0] LANE_NONE = 3'h0;
    localparam logic [2:0] LANE_WORD = 3'h3;
    localparam logic [2:0] LANE_EVEN = 3'h1;
    localparam logic [2:0] LANE_ODD = 3'h2;
    localparam logic [2:0] LANE_ODD_LOW = 3'h6;
    typedef enum logic [2:0] {sp_none, sp_common, sp_attr, sp_io, sp_task, sp_ctrl, sp_dma} fhp_space_t;
    typedef enum logic [1:0] {dma_idle, dma_req, dma_ack_wait} fhp_dma_state_t;
endpackage

// *** hw/fhp_sync.sv ***
`timescale 1ns/1ps
module fhp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a bit only moves once two later stages agree, filtering one-sample glitches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= RST_VAL;
        end else begin
            sync_out <= (stage2 & ~(stage2 ^ stage3)) | (sync_out & (stage2 ^ stage3));
        end
    end
endmodule

// *** verification/fhp_host.sv ***
`timescale 1ns/1ps
module fhp_host (
    input wire logic core_clk,
    output logic [fhp_pkg::ADDR_W-1:0] addr,
    output logic [fhp_pkg::DATA_W-1:0] data_in,
    input wire logic [fhp_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic input_ack_n,
    input wire logic dma_request,
    output logic ce1_n,
    output logic ce2_n,
    output logic attr_n,
    output logic oe_n,
    output logic io_read_strobe_n_n,
    output logic io_write_strobe_n_n,
    output logic dma_ack_n_n,
    output logic ide_mode_select_n_n
);
    import fhp_pkg::*;
    initial begin
        addr = 11'h000;
        data_in = 16'h0000;
        {ce1_n, ce2_n, attr_n, oe_n, io_read_strobe_n_n, io_write_strobe_n_n, dma_ack_n_n, ide_mode_select_n_n} = 8'hff;
    end
    ////////////////////////////////////////////////////////////////
    // strobes held 12 cycles, well past the synchroniser latency
    task automatic rd(input logic [10:0] a, input logic c1, input logic c2, input logic at,
                      input logic use_oe, input logic use_ack, output logic [15:0] d);
        d = 16'hffff;
        @(posedge core_clk);
        addr <= a;
        ce1_n <= c1;
        ce2_n <= c2;
        attr_n <= at;
        if (use_oe) oe_n <= 1'b0;
        else io_read_strobe_n_n <= 1'b0;
        repeat (12) begin
            @(posedge core_clk);
            // input buffer opened by ack only when use_ack is set
            if (data_oe === 1'b1 && (!use_ack || input_ack_n === 1'b0)) d = data_out;
        end
        {oe_n, io_read_strobe_n_n, ce1_n, ce2_n} <= 4'hf;
        addr <= ~a;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic ide_sel(input logic on);
        @(posedge core_clk);
        ide_mode_select_n_n <= !on;
    endtask
    task automatic wr(input logic [10:0] a, input logic c1, input logic c2, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        data_in <= d;
        ce1_n <= c1;
        ce2_n <= c2;
        attr_n <= 1'b0;
        io_write_strobe_n_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        io_write_strobe_n_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        {ce1_n, ce2_n} <= 2'h3;
        data_in <= ~d;
        repeat (6) @(posedge core_clk);
    endtask
    // selects stay high for the whole ack, direction set by strobe only
    task automatic dma(input logic to_card, input logic [15:0] wd, output logic [15:0] d, output logic dropped);
        int n;
        d = 16'hffff;
        dropped = 1'b0;
        for (n = 0; n < 20 && dma_request !== 1'b1; n++) @(posedge core_clk);
        {ce1_n, ce2_n} <= 2'h3;
        dma_ack_n_n <= 1'b0;
        if (to_card) begin
            data_in <= wd;
            io_write_strobe_n_n <= 1'b0;
        end else begin
            io_read_strobe_n_n <= 1'b0;
        end
        repeat (12) begin
            @(posedge core_clk);
            if (data_oe === 1'b1) d = data_out;
            if (dma_request === 1'b0) dropped = 1'b1;
        end
        {io_read_strobe_n_n, io_write_strobe_n_n, dma_ack_n_n} <= 3'h7;
        repeat (2) @(posedge core_clk);
    endtask
endmodule

// *** verification/tb_flash_card_host_port.sv ***
`timescale 1ns/1ps
module tb_flash_card_host_port;
    import fhp_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [10:0] addr;
    logic [15:0] data_in, data_out, wr_data, w_data, d;
    logic [15:0] core_rd_data = 16'hb3c5;
    logic data_oe, ce1_n, ce2_n, attr_n, oe_n, io_read_strobe_n_n, io_write_strobe_n_n, dma_ack_n_n, ide_mode_select_n_n, msel_n;
    logic input_ack_n, input_ack_oe, dma_request, dma_request_oe, cd_a_n, cd_b_n, pullup_en;
    logic io_mode_enable = 1'b0, dev_selected = 1'b0, dma_enable = 1'b0, dma_pending = 1'b0;
    logic master_slave_select_n_gnd = 1'b0, ide_mode, is_master, rd_active, wr_pulse, seen_ack, dropped;
    logic [10:0] rd_addr, wr_addr, seen_addr, w_addr;
    logic [1:0] wr_byte_en, w_be;
    fhp_space_t rd_space, wr_space, seen_space, w_space;
    int fail_count = 0, checks_done = 0, rd_cycles = 0, wcnt = 0, c;
    always #50 core_clk = ~core_clk;
    // open pin with the card pull-up on reads high
    assign msel_n = master_slave_select_n_gnd ? 1'b0 : pullup_en === 1'b1;
    fhp_port i_dut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .low_byte_card_enable_n(ce1_n), .high_byte_card_enable_n(ce2_n), .attr_space_n(attr_n),
        .output_enable_n(oe_n), .io_read_strobe_n(io_read_strobe_n_n), .io_write_strobe_n(io_write_strobe_n_n), .dma_ack_n(dma_ack_n_n),
        .master_slave_select_n(msel_n), .ide_mode_select_n(ide_mode_select_n_n), .input_ack_n(input_ack_n),
        .input_ack_oe(input_ack_oe), .dma_request(dma_request), .dma_request_oe(dma_request_oe),
        .insert_detect_a_n(cd_a_n), .insert_detect_b_n(cd_b_n), .master_slave_pullup_en(pullup_en),
        .io_mode_enable(io_mode_enable), .dev_selected(dev_selected), .dma_enable(dma_enable),
        .dma_pending(dma_pending), .core_rd_data(core_rd_data), .ide_mode(ide_mode), .is_master(is_master),
        .rd_active(rd_active), .rd_space(rd_space), .rd_addr(rd_addr), .wr_pulse(wr_pulse), .wr_space(wr_space),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_byte_en(wr_byte_en));
    fhp_host i_host (.core_clk(core_clk), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .input_ack_n(input_ack_n), .dma_request(dma_request), .ce1_n(ce1_n), .ce2_n(ce2_n), .attr_n(attr_n),
        .oe_n(oe_n), .io_read_strobe_n_n(io_read_strobe_n_n), .io_write_strobe_n_n(io_write_strobe_n_n), .dma_ack_n_n(dma_ack_n_n), .ide_mode_select_n_n(ide_mode_select_n_n));
    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (rd_active === 1'b1) begin
            rd_cycles <= rd_cycles + 1;
            seen_space <= rd_space;
            seen_addr <= rd_addr;
            seen_ack <= input_ack_n;
        end
        if (wr_pulse === 1'b1) begin
            wcnt <= wcnt + 1;
            w_space <= wr_space;
            w_addr <= wr_addr;
            w_data <= wr_data;
            w_be <= wr_byte_en;
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_mem();
        i_host.rd(11'h004, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, d);
        check("mem word", d, 16'hb3c5);
        check("mem space", seen_space, sp_common);
        check("ack oe", input_ack_oe, 1'b0);
        check("detect", {cd_a_n, cd_b_n}, 2'h0);
        i_host.rd(11'h005, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, d);
        check("odd low", d, 16'h00b3);
        check("attr space", seen_space, sp_attr);
    endtask
    task automatic t_io();
        @(posedge core_clk) io_mode_enable <= 1'b1;
        i_host.rd(11'h1f1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, d);
        check("odd high", d, 16'hb300);
        check("io space", seen_space, sp_io);
        check("ack low", seen_ack, 1'b0);
        check("ack idle", {input_ack_oe, input_ack_n}, 2'h3);
        c = rd_cycles;
        i_host.rd(11'h004, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, d);
        check("io oe common", 16'(rd_cycles - c), 16'h0);
        c = wcnt;
        i_host.wr(11'h1f3, 1'b0, 1'b1, 16'h005a);
        check("wr count", 16'(wcnt - c), 16'h1);
        check("wr addr", w_addr, 16'h01f3);
        check("wr data", w_data, 16'h5a5a);
        check("wr lanes", {w_space, w_be}, {sp_io, 2'h2});
    endtask
    task automatic t_ide();
        i_host.ide_sel(1'b1);
        // pull-up reaches the select pin only once ide is seen, then syncs again
        repeat (12) @(posedge core_clk);
        check("ide", {ide_mode, pullup_en, is_master}, 3'h6);
        @(posedge core_clk) master_slave_select_n_gnd <= 1'b1;
        dev_selected <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("master", is_master, 1'b1);
        i_host.rd(11'h7fb, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, d);
        check("task byte", d, 16'h00c5);
        check("task sel", {seen_space, seen_addr}, {sp_task, 11'h003});
        i_host.rd(11'h006, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, d);
        check("ctrl sel", {seen_space, seen_addr}, {sp_ctrl, 11'h006});
        c = wcnt;
        i_host.wr(11'h7fe, 1'b0, 1'b1, 16'h1234);
        check("ide wr count", 16'(wcnt - c), 16'h1);
        check("ide wr sel", {w_space, w_addr}, {sp_task, 11'h006});
        check("ide wr lanes", w_be, 16'h1);
        check("ide wr byte", w_data[7:0], 16'h34);
    endtask
    task automatic t_dma();
        @(posedge core_clk) dev_selected <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("req undriven", dma_request_oe, 1'b0);
        {dev_selected, dma_enable, dma_pending} <= 3'h7;
        repeat (3) @(posedge core_clk);
        check("req raised", {dma_request_oe, dma_request}, 2'h3);
        i_host.dma(1'b0, 16'h0000, d, dropped);
        check("dma word", d, 16'hb3c5);
        check("dma space", seen_space, sp_dma);
        check("req dropped", dropped, 1'b1);
        repeat (8) @(posedge core_clk);
        check("req again", dma_request, 1'b1);
        dma_pending <= 1'b0;
        c = wcnt;
        i_host.dma(1'b1, 16'ha55a, d, dropped);
        repeat (8) @(posedge core_clk);
        check("req done", dma_request, 1'b0);
        check("dma wr count", 16'(wcnt - c), 16'h1);
        check("dma wr lanes", {w_space, w_be}, {sp_dma, 2'h3});
        check("dma wr data", w_data, 16'ha55a);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_mem();
        t_io();
        t_ide();
        t_dma();
        close_out();
    end
    // whole sequence is about 230 cycles
    initial begin
        #(100 * 5000);
        fail_count++;
        close_out();
    end
endmodule
